// >>> hdl/put_timer.v
// Function
// - Counting continues in wait; irq wakes core
// - Stop freezes prescaler, counter and status
// - Irq request when enable and flag set
// - Interrupt enable resets to zero
// - Flag sets when counter wraps 00 to FF
// - Prescaler register at D2, resets 7F
// - Prescaler bit 7 reads zero, live count
// - Counter register at D3, resets FF
// - Status/control at D4, resets 00, layout
// - Run low forces prescaler 7F, counter halts
// - Run high: prescaler counts, counter on tap
// - Tap select divides by two to n
// - Prescaler fed by core clock over twelve
// - Prescaler reloads 7F after reaching zero
// - Counter reloads FF on decrement from zero
// - Coinciding counter write wins, no flag set then
`include "put_defs.vh"

module put_timer
#(
   parameter ADDR_WIDTH = 12,
   parameter CORE_DIV = `PUT_CORE_DIV
)
(
   // APB slave
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [ADDR_WIDTH-1:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output wire pready,
   output reg [31:0] prdata,
   output reg pslverr,
   // Core power state, same clock
   input wire wait_mode,
   input wire stop_mode,
   // Requests to the core
   output wire timer_irq,
   output wire wake_request
);

   localparam DIV_W = 4;
   localparam [DIV_W-1:0] DIV_LAST = CORE_DIV - 1;

   reg [6:0] prescaler_count;
   reg [7:0] timer_count_value;
   reg underflow_flag;
   reg underflow_irq_enable;
   reg reserved_set_bit;
   reg reserved_clear_bit;
   reg prescaler_run;
   reg [2:0] divider_tap_select;
   reg [DIV_W-1:0] core_div;

   reg [6:0] next_prescaler_count;
   reg [7:0] next_timer_count_value;
   reg next_underflow_flag;
   reg [DIV_W-1:0] next_core_div;
   reg [7:0] read_byte;
   reg read_hit;

   wire setup_phase;
   wire write_strobe;
   wire idx_ok;
   wire [ADDR_WIDTH-3:0] word_idx;
   wire hit_psc;
   wire hit_cnt;
   wire hit_stat;
   wire wr_psc;
   wire wr_cnt;
   wire wr_stat;
   wire frozen;
   wire core_tick;
   wire [6:0] tap_mask;
   wire count_tick;
   wire wrap;

   // Bus decode; zero-wait slave, read data captured in setup
   assign setup_phase = psel & ~penable;
   assign pready = 1'b1;
   assign write_strobe = psel & penable & pwrite & pstrb[0];
   assign word_idx = paddr[ADDR_WIDTH-1:2];
   assign idx_ok = (paddr[1:0] == 2'b00);
   assign hit_psc = idx_ok & (word_idx == `PUT_IDX_PRESCALER);
   assign hit_cnt = idx_ok & (word_idx == `PUT_IDX_COUNT);
   assign hit_stat = idx_ok & (word_idx == `PUT_IDX_STATUS);

   // Writes are dropped in stop so nothing moves while frozen
   assign frozen = stop_mode;
   assign wr_psc = write_strobe & hit_psc & ~frozen;
   assign wr_cnt = write_strobe & hit_cnt & ~frozen;
   assign wr_stat = write_strobe & hit_stat & ~frozen;

   // Core clock over twelve, gated by run; wait has no effect
   always @*
   begin
      next_core_div = core_div;
      if (!prescaler_run)
      begin
         next_core_div = {DIV_W{1'b0}};
      end
      else if (!frozen)
      begin
         if (core_div == DIV_LAST)
         begin
            next_core_div = {DIV_W{1'b0}};
         end
         else
         begin
            next_core_div = core_div + 1'b1;
         end
      end
   end

   assign core_tick = prescaler_run & ~frozen & (core_div == DIV_LAST);

   // Counter steps once every two-to-the-tap prescaler steps
   assign tap_mask = 7'h7F >> (3'd7 - divider_tap_select);
   assign count_tick = core_tick & ((prescaler_count & tap_mask) == 7'h00);
   assign wrap = count_tick & (timer_count_value == `PUT_CNT_ZERO) & ~wr_cnt;

   // Prescaler
   always @*
   begin
      next_prescaler_count = prescaler_count;
      if (!prescaler_run)
      begin
         next_prescaler_count = `PUT_PSC_RELOAD;
      end
      else if (wr_psc)
      begin
         next_prescaler_count = pwdata[6:0];
      end
      else if (core_tick)
      begin
         if (prescaler_count == 7'h00)
         begin
            next_prescaler_count = `PUT_PSC_RELOAD;
         end
         else
         begin
            next_prescaler_count = prescaler_count - 1'b1;
         end
      end
   end

   // Counter; a write overrides a decrement in the same cycle
   always @*
   begin
      next_timer_count_value = timer_count_value;
      if (wr_cnt)
      begin
         next_timer_count_value = pwdata[7:0];
      end
      else if (count_tick)
      begin
         if (timer_count_value == `PUT_CNT_ZERO)
         begin
            next_timer_count_value = `PUT_CNT_RELOAD;
         end
         else
         begin
            next_timer_count_value = timer_count_value - 1'b1;
         end
      end
   end

   // Flag: a status write loads bit 7, a wrap sets it; a wrap beats a clearing write
   always @*
   begin
      next_underflow_flag = underflow_flag;
      if (wr_stat)
      begin
         next_underflow_flag = pwdata[`PUT_BIT_FLAG];
      end
      if (wrap)
      begin
         next_underflow_flag = 1'b1;
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prescaler_count <= `PUT_RST_PRESCALER;
         timer_count_value <= `PUT_RST_COUNT;
         core_div <= {DIV_W{1'b0}};
         underflow_flag <= 1'b0;
      end
      else
      begin
         prescaler_count <= next_prescaler_count;
         timer_count_value <= next_timer_count_value;
         core_div <= next_core_div;
         underflow_flag <= next_underflow_flag;
      end
   end

   // Control fields of the status register
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         underflow_irq_enable <= 1'b0;
         reserved_set_bit <= 1'b0;
         reserved_clear_bit <= 1'b0;
         prescaler_run <= 1'b0;
         divider_tap_select <= 3'b000;
      end
      else if (wr_stat)
      begin
         underflow_irq_enable <= pwdata[`PUT_BIT_IRQ_EN];
         reserved_set_bit <= pwdata[`PUT_BIT_RSV_SET];
         reserved_clear_bit <= pwdata[`PUT_BIT_RSV_CLR];
         prescaler_run <= pwdata[`PUT_BIT_RUN];
         divider_tap_select <= pwdata[`PUT_TAP_HI:`PUT_TAP_LO];
      end
   end

   // Read mux
   always @*
   begin
      read_byte = 8'h00;
      read_hit = 1'b1;
      if (hit_psc)
      begin
         read_byte = {1'b0, prescaler_count};
      end
      else if (hit_cnt)
      begin
         read_byte = timer_count_value;
      end
      else if (hit_stat)
      begin
         read_byte = {underflow_flag, underflow_irq_enable, reserved_set_bit,
                      reserved_clear_bit, prescaler_run, divider_tap_select};
      end
      else
      begin
         read_hit = 1'b0;
      end
   end

   // Registered answer, ready by the access phase
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else if (setup_phase)
      begin
         prdata <= {24'h00_0000, read_byte};
         pslverr <= ~read_hit;
      end
   end

   // Level request; wait mode leaves it untouched
   assign timer_irq = underflow_flag & underflow_irq_enable;
   assign wake_request = timer_irq & wait_mode;

endmodule

// >>> hdl/put_defs.vh
`ifndef PUT_DEFS_VH
`define PUT_DEFS_VH

// Register indices; byte address is four times the index
`define PUT_IDX_PRESCALER 10'h0D2
`define PUT_IDX_COUNT 10'h0D3
`define PUT_IDX_STATUS 10'h0D4

// Reset values
`define PUT_RST_PRESCALER 7'h7F
`define PUT_RST_COUNT 8'hFF
`define PUT_RST_STATUS 8'h00

// Prescaler reload and counter reload
`define PUT_PSC_RELOAD 7'h7F
`define PUT_CNT_RELOAD 8'hFF
`define PUT_CNT_ZERO 8'h00

// Status/control field positions
`define PUT_BIT_FLAG 7
`define PUT_BIT_IRQ_EN 6
`define PUT_BIT_RSV_SET 5
`define PUT_BIT_RSV_CLR 4
`define PUT_BIT_RUN 3
`define PUT_TAP_HI 2
`define PUT_TAP_LO 0

// Core clock divided by this feeds the prescaler
`define PUT_CORE_DIV 12

`endif

// >>> test/put_timer_chk.sv
module put_timer_chk
#(
   parameter ADDR_WIDTH = 12
)
(
   // APB
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [ADDR_WIDTH-1:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   input wire pready,
   input wire [31:0] prdata,
   input wire pslverr,
   // Power and requests
   input wire wait_mode,
   input wire stop_mode,
   input wire timer_irq,
   input wire wake_request
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire mapped = paddr == 12'h348 || paddr == 12'h34c || paddr == 12'h350;
   sequence s_setup(a);
      psel && !penable && paddr == a;
   endsequence
   a_wake_level: assert property (wake_request == (timer_irq && wait_mode))
      else $error("wake");
   a_stop_hold: assert property (stop_mode |=> $stable(timer_irq)) else $error("stop");
   a_irq_reset: assert property ($rose(presetn) |-> !timer_irq) else $error("rst");
   a_bad_addr: assert property (psel && !penable && !mapped |=> pslverr && prdata == 0)
      else $error("unmapped");
   a_good_addr: assert property (psel && !penable && mapped |=> !pslverr)
      else $error("mapped");
   a_psc_msb: assert property (s_setup(12'h348) |=> prdata[31:7] == 0)
      else $error("msb");
   a_irq_status: assert property (s_setup(12'h350) |=>
      (prdata[7] && prdata[6]) == $past(timer_irq)) else $error("irq");
   // Only a status write may drop the request
   a_irq_holds: assert property (timer_irq && !(psel && paddr == 12'h350) |=> timer_irq)
      else $error("hold");
endmodule

bind put_timer put_timer_chk #(.ADDR_WIDTH(ADDR_WIDTH)) u_chk (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
   .wait_mode(wait_mode), .stop_mode(stop_mode), .timer_irq(timer_irq),
   .wake_request(wake_request));

// >>> test/put_timer_test.sv
module put_timer_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
   logic wait_mode = 0, stop_mode = 0, pready, pslverr, timer_irq, wake_request;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata;
   logic [7:0] rd;
   int fail_count = 0, tests_run = 0, n;
   always #10 pclk = ~pclk;
   put_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .wait_mode(wait_mode), .stop_mode(stop_mode),
      .timer_irq(timer_irq), .wake_request(wake_request));
   task results;
      $display("mismatches %0d checks %0d", fail_count, tests_run);
      if (fail_count == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD %0t %h %h", $time, got, exp);
      end
   endtask
   // Extra edge after release keeps psel from being driven twice in one step
   task bus(input logic w, input logic [11:0] a, input logic [7:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h00_0000, d};
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd = prdata[7:0];
      er = pslverr;
      psel <= 0;
      penable <= 0;
      if (n == 20)
      begin
         fail_count++;
         results;
      end
      @(posedge pclk);
   endtask
   task t_reset;
      bus(0, 12'h348, 0);
      chk(rd, 8'h7f);
      bus(0, 12'h34c, 0);
      chk(rd, 8'hff);
      bus(0, 12'h350, 0);
      chk(rd, 8'h00);
      bus(0, 12'h354, 0);
      chk({7'h00, er}, 8'h01);
   endtask
   task t_wrap;
      bus(1, 12'h350, 8'h28);
      bus(1, 12'h34c, 8'h00);
      n = 0;
      do
      begin
         bus(0, 12'h34c, 0);
         n++;
      end
      while (rd !== 8'hff && n < 30);
      chk(rd, 8'hff);
      bus(0, 12'h350, 0);
      chk(rd, 8'ha8);
   endtask
   task t_irq;
      wait_mode <= 1;
      bus(1, 12'h350, 8'he8);
      chk({6'h00, timer_irq, wake_request}, 8'h03);
      bus(1, 12'h350, 8'h68);
      chk({6'h00, timer_irq, wake_request}, 8'h00);
      bus(1, 12'h350, 8'ha8);
      chk({7'h00, timer_irq}, 8'h00);
      wait_mode <= 0;
   endtask
   task t_halt;
      bus(1, 12'h350, 8'h20);
      bus(1, 12'h34c, 8'h33);
      repeat (40) @(posedge pclk);
      bus(0, 12'h34c, 0);
      chk(rd, 8'h33);
      bus(0, 12'h348, 0);
      chk(rd, 8'h7f);
   endtask
   task t_stop;
      bus(1, 12'h34c, 8'h40);
      bus(1, 12'h350, 8'h28);
      stop_mode <= 1;
      repeat (60) @(posedge pclk);
      bus(1, 12'h34c, 8'h99);
      bus(0, 12'h34c, 0);
      chk(rd, 8'h40);
      stop_mode <= 0;
   endtask
   // Run low first so the divider restarts from zero
   task t_tick;
      bus(1, 12'h350, 8'h20);
      bus(1, 12'h350, 8'h28);
      repeat (10) @(posedge pclk);
      bus(0, 12'h348, 0);
      chk(rd, 8'h7f);
      bus(0, 12'h348, 0);
      chk(rd, 8'h7e);
   endtask
   // Top tap needs a prescaler zero, far beyond this wait
   task t_tap;
      bus(1, 12'h350, 8'h20);
      bus(1, 12'h34c, 8'h05);
      bus(1, 12'h350, 8'h2f);
      repeat (300) @(posedge pclk);
      bus(0, 12'h34c, 0);
      chk(rd, 8'h05);
   endtask
   initial
   begin
      repeat (20) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      t_reset;
      t_wrap;
      t_irq;
      t_halt;
      t_stop;
      t_tick;
      t_tap;
      results;
   end
endmodule
